// ### src/cfl_regs.vh
// Purpose: Register offsets, field positions, reset values and limits of the controller.
// Assumes: APB with 32-bit data and one aligned word per register.
// Notes: Included by the controller and its counter store.
`ifndef CFL_REGS_VH
`define CFL_REGS_VH
`define CFL_MODE_OFS 8'h00
`define CFL_IER_OFS 8'h04
`define CFL_IDR_OFS 8'h08
`define CFL_IMR_OFS 8'h0c
`define CFL_SR_OFS 8'h10
`define CFL_BR_OFS 8'h14
`define CFL_ECR_OFS 8'h18
`define CFL_EVT_OFS 8'h1c
`define CFL_MODE_EN 0
`define CFL_MODE_LPM 1
`define CFL_MODE_ABM 2
`define CFL_MODE_OVL 3
`define CFL_SR_MBOX 0
`define CFL_SR_ERROR_ACTIVE_FLAG 16
`define CFL_SR_WARN 17
`define CFL_SR_ERROR_PASSIVE_FLAG 18
`define CFL_SR_BUS_OFF_FLAG 19
`define CFL_SR_SLEEP 20
`define CFL_SR_WAKE 21
`define CFL_SR_BUSY 22
`define CFL_SRC_MASK 32'h003f00ff
`define CFL_WARN_LIMIT 9'd96
`define CFL_PASSIVE_LIMIT 9'd127
`define CFL_BUS_OFF_FLAG_LIMIT 9'd255
`define CFL_SYNC_BITS 4'd11
`define CFL_BR_RESET 32'h00000000
`endif

// ### src/cfl_err_counters.v
// Purpose: Holds the transmit and receive error counters and updates them.
// Assumes: One-cycle event pulses from the protocol engine.
// Notes: Read data come out of registers; a clear has priority over any event.
`include "cfl_regs.vh"
module cfl_err_counters
(
    // Clock and reset.
    input wire mclk,
    input wire arst_n,
    // Control.
    input wire clear,
    input wire freeze,
    // Counting events.
    input wire txErr,
    input wire txOk,
    input wire rxErr,
    input wire rxOk,
    // Counter values.
    output reg [8:0] txCount_q,
    output reg [7:0] rxCount_q
);

    // Saturating counters; errors add eight on transmit and one on receive.
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            txCount_q <= 9'h000;
            rxCount_q <= 8'h00;
        end
        else if (clear)
        begin
            txCount_q <= 9'h000;
            rxCount_q <= 8'h00;
        end
        else if (!freeze)
        begin
            if (txErr)
                txCount_q <= (txCount_q > 9'h1f7) ? 9'h1ff : txCount_q + 9'h008;
            else if (txOk && txCount_q != 9'h000)
                txCount_q <= txCount_q - 9'h001;
            if (rxErr)
                rxCount_q <= (rxCount_q == 8'hff) ? 8'hff : rxCount_q + 8'h01;
            else if (rxOk && rxCount_q != 8'h00)
                rxCount_q <= rxCount_q - 8'h01;
        end
    end

endmodule // cfl_err_counters

// ### src/cfl_ctrl.v
// Purpose: Fault confinement, overload frames, low-power mode and interrupt masking.
// Assumes: A protocol engine gives per-bit pulses and frame events on mclk.
// Notes: Bit timing and mailbox storage sit outside; this block steers them.
//
// Contract
// - Keep readable TX/RX counters; derive state.
// - Error-active sets flag; interrupt if unmasked.
// - Error-passive: flag, passive frames, transmit wait.
// - Bus-off: flag, interrupt, no bus influence.
// - Counter above 96 sets warning flag.
// - Reactive overload on listed dominant bits.
// - Overload enable sends request overload frames.
// - Reactive overload always; counters untouched.
// - Low-power: no transfer, mailboxes inactive.
// - Sleep/wake exclusive; both zero after reset.
// - Power-up: no low-power; wake after 11.
// - Low-power request: drain transmits, then sleep.
// - Setting wake clears sleep, and reverse.
// - Sleep disables reception, freezes counters.
// - Leave low-power: resync eleven bits, wake.
// - Idle bus: transmit eleven bits later.
// - Enable resets engine, counters, error flags.
// - Autobaud locks counters, flags still update.
// - Enable/disable writes mask; mask readable.
// - Mailbox and system interrupt sources.
// - Warning only while error-active.
//
// Register access over APB and the register offsets were chosen for this implementation.
`include "cfl_regs.vh"
module cfl_ctrl
#(
    parameter MBOX_NUM = 8
)
(
    // Clock and reset.
    input wire mclk,
    input wire arst_n,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Bus line from the pin, recessive high.
    input wire canRx,
    // Protocol engine events; interFrameBit and txPending are levels, the rest one-cycle pulses.
    input wire bitTick,
    input wire interFrameBit,
    input wire eofLastBit,
    input wire delimLastBit,
    input wire txOkEvt,
    input wire txErrEvt,
    input wire rxOkEvt,
    input wire rxErrEvt,
    input wire rxForUs,
    input wire txPending,
    input wire [MBOX_NUM-1:0] mboxEvt,
    // Steering outputs to the protocol engine, and the interrupt line.
    output reg engineReset,
    output reg txAllowed,
    output reg rxAllowed,
    output reg passiveFlags,
    output reg busDriveEn,
    output reg overloadStart,
    output reg suspendWait,
    output reg [31:0] bitTiming,
    output reg irq
);

    // State encodings.
    localparam FC_ACTIVE = 2'd0;
    localparam FC_PASSIVE = 2'd1;
    localparam FC_BUSOFF = 2'd2;
    localparam LP_SYNC = 2'd0;
    localparam LP_AWAKE = 2'd1;
    localparam LP_DRAIN = 2'd2;
    localparam LP_SLEEP = 2'd3;

    reg [31:0] rdata_d;
    reg [3:0] mode_q;
    reg [31:0] mask_q;
    reg [MBOX_NUM-1:0] mboxFlag_q;
    reg [1:0] lpState_q;
    reg [3:0] recCount_q;
    reg rx1_q;
    reg rx2_q;
    reg enPrev_q;
    reg lpmPrev_q;
    reg sleep_q;
    reg wake_q;
    reg [1:0] ifsCount_q;
    wire [8:0] txCount;
    wire [7:0] rxCount;
    wire [1:0] fcState;
    wire warn;
    wire [31:0] status;
    wire wr;
    wire rd;
    wire enRise;
    wire freeze;

    // Fault state from the counter values.
    function [1:0] fc_state;
        input [8:0] tx;
        input [7:0] rx;
        begin
            if (tx > `CFL_BUS_OFF_FLAG_LIMIT)
                fc_state = FC_BUSOFF;
            else if (tx > `CFL_PASSIVE_LIMIT || {1'b0, rx} > `CFL_PASSIVE_LIMIT)
                fc_state = FC_PASSIVE;
            else
                fc_state = FC_ACTIVE;
        end
    endfunction

    // Bus access strobes; every access completes in its first access cycle.
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign enRise = mode_q[`CFL_MODE_EN] && !enPrev_q;
    assign freeze = sleep_q || mode_q[`CFL_MODE_ABM] || enRise;
    assign fcState = fc_state(txCount, rxCount);
    assign warn = (fcState == FC_ACTIVE)
        && (txCount > `CFL_WARN_LIMIT || {1'b0, rxCount} > `CFL_WARN_LIMIT);

    // Status word; fault, warning and power sources are level driven, mailbox flags are sticky.
    assign status = {9'h000, lpState_q != LP_AWAKE, wake_q, sleep_q,
        fcState == FC_BUSOFF, fcState == FC_PASSIVE, warn, fcState == FC_ACTIVE,
        {(16 - MBOX_NUM){1'b0}}, mboxFlag_q};

    // Counter store, cleared on enable.
    cfl_err_counters u_counters
    (
        .mclk(mclk),
        .arst_n(arst_n),
        .clear(enRise),
        .freeze(freeze),
        .txErr(txErrEvt),
        .txOk(txOkEvt),
        .rxErr(rxErrEvt && rxAllowed),
        .rxOk(rxOkEvt && rxAllowed),
        .txCount_q(txCount),
        .rxCount_q(rxCount)
    );

    // Read multiplexer.
    always @*
    begin
        case (paddr)
            `CFL_MODE_OFS: rdata_d = {28'h0000000, mode_q};
            `CFL_IMR_OFS: rdata_d = mask_q;
            `CFL_SR_OFS: rdata_d = status;
            `CFL_BR_OFS: rdata_d = bitTiming;
            `CFL_ECR_OFS: rdata_d = {7'h00, txCount, 8'h00, rxCount};
            default: rdata_d = 32'h00000000;
        endcase
    end

    // APB answer and register writes.
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            mode_q <= 4'h0;
            mask_q <= 32'h00000000;
            bitTiming <= `CFL_BR_RESET;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !(paddr[7:5] == 3'b000 && paddr[1:0] == 2'b00);
            if (rd)
                prdata <= rdata_d;
            if (wr)
            begin
                case (paddr)
                    `CFL_MODE_OFS: mode_q <= pwdata[3:0];
                    `CFL_IER_OFS: mask_q <= mask_q | (pwdata & `CFL_SRC_MASK);
                    `CFL_IDR_OFS: mask_q <= mask_q & ~pwdata;
                    `CFL_BR_OFS: bitTiming <= pwdata;
                    default: mask_q <= mask_q;
                endcase
            end
        end
    end

    // Bus line synchroniser and edge history.
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx1_q <= 1'b1;
            rx2_q <= 1'b1;
            enPrev_q <= 1'b0;
            lpmPrev_q <= 1'b0;
        end
        else
        begin
            rx1_q <= canRx;
            rx2_q <= rx1_q;
            enPrev_q <= mode_q[`CFL_MODE_EN];
            lpmPrev_q <= mode_q[`CFL_MODE_LPM];
        end
    end

    // Low-power and synchronisation sequence.
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lpState_q <= LP_SYNC;
            recCount_q <= 4'h0;
            sleep_q <= 1'b0;
            wake_q <= 1'b0;
        end
        else if (!mode_q[`CFL_MODE_EN] || enRise)
        begin
            lpState_q <= LP_SYNC;
            recCount_q <= 4'h0;
            sleep_q <= 1'b0;
            wake_q <= 1'b0;
        end
        else
        begin
            case (lpState_q)
                LP_SYNC:
                begin
                    if (mode_q[`CFL_MODE_LPM])
                        recCount_q <= 4'h0;
                    else if (bitTick)
                    begin
                        if (!rx2_q)
                            recCount_q <= 4'h0;
                        else if (recCount_q == `CFL_SYNC_BITS - 4'h1)
                        begin
                            lpState_q <= LP_AWAKE;
                            wake_q <= 1'b1;
                            sleep_q <= 1'b0;
                            recCount_q <= 4'h0;
                        end
                        else
                            recCount_q <= recCount_q + 4'h1;
                    end
                end
                LP_AWAKE:
                begin
                    if (mode_q[`CFL_MODE_LPM] && !lpmPrev_q)
                        lpState_q <= LP_DRAIN;
                end
                LP_DRAIN:
                begin
                    if (!mode_q[`CFL_MODE_LPM])
                        lpState_q <= LP_AWAKE;
                    else if (!txPending)
                    begin
                        lpState_q <= LP_SLEEP;
                        sleep_q <= 1'b1;
                        wake_q <= 1'b0;
                    end
                end
                LP_SLEEP:
                begin
                    if (!mode_q[`CFL_MODE_LPM])
                        lpState_q <= LP_SYNC;
                end
                default: lpState_q <= LP_SYNC;
            endcase
        end
    end

    // Mailbox flags, a new event wins over an acknowledging write.
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            mboxFlag_q <= {MBOX_NUM{1'b0}};
        else if (lpState_q == LP_SLEEP || !mode_q[`CFL_MODE_EN])
            mboxFlag_q <= {MBOX_NUM{1'b0}};
        else if (wr && paddr == `CFL_EVT_OFS)
            mboxFlag_q <= (mboxFlag_q & ~pwdata[MBOX_NUM-1:0]) | mboxEvt;
        else
            mboxFlag_q <= mboxFlag_q | mboxEvt;
    end

    // Overload control and intermission bit count.
    // Bus-off and error-passive entry reach software through the level status bits.
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            overloadStart <= 1'b0;
            ifsCount_q <= 2'd0;
        end
        else
        begin
            if (!interFrameBit)
                ifsCount_q <= 2'd0;
            else if (bitTick && ifsCount_q != 2'd3)
                ifsCount_q <= ifsCount_q + 2'd1;
            // Reactive cases regardless of enable; counters not touched.
            overloadStart <= bitTick && !rx2_q && fcState != FC_BUSOFF
                && lpState_q == LP_AWAKE
                && ((interFrameBit && ifsCount_q < 2'd2) || eofLastBit
                || delimLastBit);
            if (mode_q[`CFL_MODE_OVL] && rxForUs && lpState_q == LP_AWAKE)
                overloadStart <= 1'b1;
        end
    end

    // Steering outputs and interrupt line, all registered.
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            engineReset <= 1'b1;
            txAllowed <= 1'b0;
            rxAllowed <= 1'b0;
            passiveFlags <= 1'b0;
            busDriveEn <= 1'b0;
            suspendWait <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            engineReset <= !mode_q[`CFL_MODE_EN] || enRise;
            txAllowed <= lpState_q == LP_AWAKE && fcState != FC_BUSOFF
                && !mode_q[`CFL_MODE_ABM];
            rxAllowed <= (lpState_q == LP_AWAKE || lpState_q == LP_DRAIN)
                && !sleep_q;
            passiveFlags <= fcState == FC_PASSIVE;
            suspendWait <= fcState == FC_PASSIVE;
            busDriveEn <= fcState != FC_BUSOFF && mode_q[`CFL_MODE_EN]
                && lpState_q != LP_SLEEP;
            irq <= |(status & mask_q);
        end
    end

endmodule // cfl_ctrl

// ### verification/cfl_ctrl_chk.sv
// Purpose: Port assertions for cfl_ctrl.
// Assumes: Status word at 8'h10, mask disable at 8'h08, map ends at 8'h1c.
// Notes: Status relations are judged at the edge where a status read completes.
module cfl_ctrl_chk
#(
    parameter MBOX_NUM = 8
)
(
    // Clock and reset.
    input wire mclk,
    input wire arst_n,
    // Register bus.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Steering and interrupt.
    input wire txAllowed,
    input wire rxAllowed,
    input wire passiveFlags,
    input wire busDriveEn,
    input wire irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    // A finishing status read, and a write that masks every source.
    sequence s_sr;
        pready && psel && !pwrite && paddr == 8'h10;
    endsequence
    sequence s_mask_off;
        psel && penable && pwrite && paddr == 8'h08 && pwdata == 32'hffffffff;
    endsequence
    property p_bad_addr;
        psel && !penable && (paddr > 8'h1c || paddr[1:0] != 2'b00) |=> pready && pslverr;
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("bad address not refused");
    property p_ready;
        pready |=> !pready;
    endproperty
    a_ready: assert property (p_ready) else $error("ready held too long");
    property p_idr;
        s_mask_off |=> ##1 !irq [*2];
    endproperty
    a_idr: assert property (p_idr) else $error("irq high with all masked");
    property p_passive;
        s_sr ##0 prdata[18] |-> passiveFlags;
    endproperty
    a_passive: assert property (p_passive) else $error("passive frames off");
    property p_bus_off_flag;
        s_sr ##0 prdata[19] |-> !busDriveEn;
    endproperty
    a_bus_off_flag: assert property (p_bus_off_flag) else $error("bus driven in bus-off");
    property p_excl;
        s_sr |-> !(prdata[20] && prdata[21]);
    endproperty
    a_excl: assert property (p_excl) else $error("sleep and wake both set");
    property p_sleep;
        s_sr ##0 prdata[20] |-> !txAllowed && !rxAllowed;
    endproperty
    a_sleep: assert property (p_sleep) else $error("transfer allowed asleep");
    property p_warn;
        s_sr ##0 prdata[17] |-> prdata[16] && !prdata[18];
    endproperty
    a_warn: assert property (p_warn) else $error("warning outside active");
endmodule // cfl_ctrl_chk
bind cfl_ctrl cfl_ctrl_chk #(.MBOX_NUM(MBOX_NUM)) u_chk (.mclk, .arst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .txAllowed, .rxAllowed,
    .passiveFlags, .busDriveEn, .irq);

// ### verification/cfl_bus_node.sv
// Purpose: Other nodes on the bus: bit sample points and line level.
// Assumes: A bit lasts BIT_CYC mclk cycles.
// Notes: The line has a pull-up, so it is recessive unless dominant is asked.
module cfl_bus_node
#(
    parameter BIT_CYC = 4
)
(
    // Clock and reset.
    input wire mclk,
    input wire arst_n,
    // Requested level and bus outputs.
    input wire dominant,
    output logic bitTick,
    output logic canRx
);
    logic [7:0] phase_q;
    // One sample point per bit.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase_q <= 8'h00;
            bitTick <= 1'b0;
        end
        else
        begin
            phase_q <= (phase_q == 8'(BIT_CYC - 1)) ? 8'h00 : phase_q + 8'h01;
            bitTick <= (phase_q == 8'(BIT_CYC - 1));
        end
    end
    // Recessive idle bits let the node synchronise.
    assign canRx = !dominant;
endmodule // cfl_bus_node

// ### verification/cfl_ctrl_test.sv
// Purpose: Self-checking bench for cfl_ctrl.
// Assumes: Bus answers in the first access cycle; a bit lasts four mclk cycles.
// Notes: Engine events are driven away from register accesses.
module cfl_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] ev = 8'h00;
    logic [7:0] mboxEvt = 8'h00;
    logic txPending = 1'b0;
    logic dom = 1'b0;
    logic ovlSeen = 1'b0;
    logic [31:0] prdata, bitTiming, r;
    logic pready, pslverr, bitTick, canRx, txAllowed, rxAllowed, passiveFlags;
    logic busDriveEn, overloadStart, irq, e, engineReset, suspendWait;
    int err_total = 0;
    int cmp_count = 0;
    // Clock at 50 MHz.
    always #10 mclk = ~mclk;
    // Note any overload start.
    always @(posedge mclk) if (overloadStart === 1'b1) ovlSeen <= 1'b1;
    cfl_bus_node node (.mclk, .arst_n, .dominant(dom), .bitTick, .canRx);
    cfl_ctrl uut (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .canRx, .bitTick, .interFrameBit(ev[5]), .eofLastBit(ev[6]),
        .delimLastBit(ev[7]), .txOkEvt(ev[0]), .txErrEvt(ev[1]), .rxOkEvt(ev[2]),
        .rxErrEvt(ev[3]), .rxForUs(ev[4]), .txPending, .mboxEvt, .engineReset,
        .txAllowed, .rxAllowed, .passiveFlags, .busDriveEn, .overloadStart,
        .suspendWait, .bitTiming, .irq);
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One bus transfer; read data and error land in r and e.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        if (n >= 20) chk("pready", 32'h0, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input int i, input int n);
        repeat (n)
        begin
            @(posedge mclk);
            ev[i] <= 1'b1;
            @(posedge mclk);
            ev[i] <= 1'b0;
        end
    endtask
    task automatic waitsr(input int b);
        for (int n = 0; n < 60; n++)
        begin
            apb(1'b0, 8'h10, 32'h0);
            if (r[b] === 1'b1) break;
        end
    endtask
    task automatic t_reset_enable();
        chk("engine_held", {31'h0, engineReset}, 32'h1);
        apb(1'b0, 8'h0c, 32'h0);
        chk("mask", r, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk("sleep_wake", r & 32'h00300000, 32'h0);
        apb(1'b1, 8'h14, 32'h00a5005a);
        apb(1'b0, 8'h14, 32'h0);
        chk("timing", bitTiming, 32'h00a5005a);
        chk("timing_rd", r, 32'h00a5005a);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk("early_wake", r & 32'h00300000, 32'h0);
        waitsr(21);
        chk("wake", r & 32'h00300000, 32'h00200000);
        chk("engine_run", {31'h0, engineReset}, 32'h0);
    endtask
    task automatic t_irq();
        apb(1'b1, 8'h04, 32'h00200001);
        apb(1'b0, 8'h0c, 32'h0);
        chk("mask_set", r, 32'h00200001);
        chk("irq_on", {31'h0, irq}, 32'h1);
        @(posedge mclk);
        mboxEvt <= 8'h01;
        @(posedge mclk);
        mboxEvt <= 8'h00;
        apb(1'b0, 8'h10, 32'h0);
        chk("mailbox", r & 32'h1, 32'h1);
        apb(1'b1, 8'h1c, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk("mbox_clr", r & 32'h1, 32'h0);
        apb(1'b1, 8'h08, 32'hffffffff);
        apb(1'b0, 8'h0c, 32'h0);
        chk("irq_off", {r[0], irq}, 32'h0);
    endtask
    task automatic t_overload();
        for (int i = 5; i < 8; i++)
        begin
            ovlSeen <= 1'b0;
            @(posedge mclk);
            ev[i] <= 1'b1;
            dom <= 1'b1;
            repeat (8) @(posedge mclk);
            ev[i] <= 1'b0;
            dom <= 1'b0;
            repeat (3) @(posedge mclk);
            chk("reactive", {31'h0, ovlSeen}, 32'h1);
        end
        ovlSeen <= 1'b0;
        pulse(4, 1);
        repeat (4) @(posedge mclk);
        chk("no_request", {31'h0, ovlSeen}, 32'h0);
        apb(1'b1, 8'h00, 32'h9);
        pulse(4, 1);
        repeat (4) @(posedge mclk);
        chk("request", {31'h0, ovlSeen}, 32'h1);
        apb(1'b1, 8'h00, 32'h5);
        pulse(1, 2);
        apb(1'b0, 8'h18, 32'h0);
        chk("locked", r, 32'h0);
        chk("abm_no_tx", {31'h0, txAllowed}, 32'h0);
        apb(1'b1, 8'h00, 32'h1);
    endtask
    task automatic t_errors();
        pulse(3, 2);
        pulse(2, 1);
        pulse(1, 13);
        apb(1'b0, 8'h18, 32'h0);
        chk("counters", r, 32'h00680001);
        apb(1'b0, 8'h10, 32'h0);
        chk("warn", r & 32'h000f0000, 32'h00030000);
        pulse(1, 3);
        apb(1'b0, 8'h10, 32'h0);
        chk("passive", r & 32'h000f0000, 32'h00040000);
        chk("passive_frames", {31'h0, passiveFlags}, 32'h1);
        chk("passive_wait", {31'h0, suspendWait}, 32'h1);
        pulse(0, 1);
        apb(1'b0, 8'h10, 32'h0);
        chk("back_active", r & 32'h000f0000, 32'h00030000);
        pulse(1, 17);
        apb(1'b0, 8'h10, 32'h0);
        chk("bus_off", {r[19], busDriveEn}, 32'h2);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b0, 8'h18, 32'h0);
        chk("cleared", r, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk("flags", r & 32'h000e0000, 32'h0);
        waitsr(21);
    endtask
    task automatic t_lowpower();
        txPending <= 1'b1;
        apb(1'b1, 8'h00, 32'h3);
        repeat (8) @(posedge mclk);
        apb(1'b0, 8'h10, 32'h0);
        chk("held_awake", r & 32'h00300000, 32'h00200000);
        txPending <= 1'b0;
        waitsr(20);
        chk("asleep", r & 32'h00300000, 32'h00100000);
        chk("no_transfer", {txAllowed, rxAllowed}, 32'h0);
        pulse(1, 1);
        apb(1'b0, 8'h18, 32'h0);
        chk("frozen", r, 32'h0);
        apb(1'b1, 8'h00, 32'h1);
        waitsr(21);
        chk("awake", r & 32'h00300000, 32'h00200000);
        chk("tx_ready", {31'h0, txAllowed}, 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", {e, r[30:0]}, 32'h80000000);
        apb(1'b1, 8'h02, 32'h1);
        chk("unaligned", {31'h0, e}, 32'h1);
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Main sequence.
    initial
    begin
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        t_reset_enable();
        t_irq();
        t_overload();
        t_errors();
        t_lowpower();
        print_verdict();
    end
    // Cut a hung run short.
    initial
    begin
        #400000;
        err_total++;
        print_verdict();
    end
endmodule // cfl_ctrl_test
